//--- hdl/sio_pin_pkg.sv
// constants, register map and carrier types of the serial pin routing block
package sio_pin_pkg;

  localparam int NUM_CH  = 3;
  localparam int NUM_RUN = 4;
  localparam int NUM_TMR = 6;

  // register indices; byte address is four times the index
  localparam logic [19:0] IDX_RX_FILTER_ENABLE     = 20'hF0060;
  localparam logic [19:0] IDX_RUN_STATUS           = 20'hF0120;
  localparam logic [19:0] IDX_START_TRIGGER        = 20'hF0122;
  localparam logic [19:0] IDX_STOP_TRIGGER         = 20'hF0124;
  localparam logic [19:0] IDX_PIN_OUTPUT_LEVELS    = 20'hF0128;
  localparam logic [19:0] IDX_OUTPUT_DRIVE_ENABLE  = 20'hF012A;
  localparam logic [19:0] IDX_TX_LEVEL_INVERSION   = 20'hF0134;
  localparam logic [19:0] IDX_INPUT_ROUTING_SWITCH = 20'hFFF3C;

  localparam logic [21:0] ADDR_RX_FILTER_ENABLE     = {IDX_RX_FILTER_ENABLE, 2'b00};
  localparam logic [21:0] ADDR_RUN_STATUS           = {IDX_RUN_STATUS, 2'b00};
  localparam logic [21:0] ADDR_START_TRIGGER        = {IDX_START_TRIGGER, 2'b00};
  localparam logic [21:0] ADDR_STOP_TRIGGER         = {IDX_STOP_TRIGGER, 2'b00};
  localparam logic [21:0] ADDR_PIN_OUTPUT_LEVELS    = {IDX_PIN_OUTPUT_LEVELS, 2'b00};
  localparam logic [21:0] ADDR_OUTPUT_DRIVE_ENABLE  = {IDX_OUTPUT_DRIVE_ENABLE, 2'b00};
  localparam logic [21:0] ADDR_TX_LEVEL_INVERSION   = {IDX_TX_LEVEL_INVERSION, 2'b00};
  localparam logic [21:0] ADDR_INPUT_ROUTING_SWITCH = {IDX_INPUT_ROUTING_SWITCH, 2'b00};

  // reset values
  localparam logic [15:0] RST_PIN_OUTPUT_LEVELS    = 16'h0F0F;
  localparam logic [2:0]  RST_OUTPUT_DRIVE_ENABLE  = 3'h0;
  localparam logic [1:0]  RST_TX_LEVEL_INVERSION   = 2'h0;
  localparam logic [4:0]  RST_INPUT_ROUTING_SWITCH = 5'h00;
  localparam logic [1:0]  RST_RX_FILTER_ENABLE     = 2'h0;
  localparam logic [3:0]  RST_RUN_STATUS           = 4'h0;

  // field positions
  localparam int POS_DATA_LEVEL  = 0;
  localparam int POS_CLOCK_LEVEL = 8;
  localparam int POS_INV_CH0     = 0;
  localparam int POS_INV_CH2     = 2;
  localparam int POS_EXTINT_SEL  = 0;
  localparam int POS_TIMER7_SEL  = 1;
  localparam int POS_SHARED_SEL  = 2;
  localparam int POS_FILTER_CH0  = 0;
  localparam int POS_FILTER_CH2  = 2;

  // shared timer pin selection codes
  localparam logic [2:0] SHARED_TO_CH1  = 3'h0;
  localparam logic [2:0] SHARED_TO_CH0  = 3'h1;
  localparam logic [2:0] SHARED_TO_CH8  = 3'h2;
  localparam logic [2:0] SHARED_TO_CH9  = 3'h3;
  localparam logic [2:0] SHARED_TO_CH10 = 3'h4;
  localparam logic [2:0] SHARED_TO_CH11 = 3'h5;

  // level updates from the running serial transfer
  typedef struct packed {
    logic [NUM_CH-1:0] data_we;
    logic [NUM_CH-1:0] data_lvl;
    logic [NUM_CH-1:0] clock_we;
    logic [NUM_CH-1:0] clock_lvl;
  } xfer_update_t;

  // serial output pins
  typedef struct packed {
    logic [NUM_CH-1:0] data;
    logic [NUM_CH-1:0] clock;
  } serial_pins_t;

  // timer array side of the shared pin; index order follows selection code
  typedef struct packed {
    logic [NUM_TMR-1:0] use_shared;
    logic               shared_in;
    logic               ch7_in;
  } timer_route_t;

endpackage : sio_pin_pkg

//--- hdl/pin_sync_filter.sv
// three-stage pin synchroniser with optional two-sample match filter
`timescale 1ns/1ps
module pin_sync_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  input  wire logic filter_en,
  output logic      level
);
  import sio_pin_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_state.s1 = pin_async;
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    if (!filter_en || (state_ff.s2 == state_ff.s3))
    begin
      nxt_state.lvl = state_ff.s3;
    end
  end

  // pins idle high, so the chain starts high to avoid a false edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign level = state_ff.lvl;

endmodule : pin_sync_filter

//--- hdl/sio_pin_route.sv
// top of the serial pin output and input routing block with APB registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module sio_pin_route (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire sio_pin_pkg::xfer_update_t  xfer_update,
  output sio_pin_pkg::serial_pins_t       serial_pins,
  output logic [3:0]                      channel_run_status,
  input  wire logic                       uart0_receive_pin,
  input  wire logic                       uart2_receive_pin,
  output logic                            uart0_rx_level,
  output logic                            uart2_rx_level,
  input  wire logic                       external_interrupt_zero,
  output logic                            extint0_level,
  input  wire logic                       timer7_input_pin,
  input  wire logic                       shared_timer_pin_i,
  output logic                            shared_timer_pin_o,
  output logic                            shared_timer_pin_oe,
  input  wire logic [5:0]                 timer_array_out,
  output sio_pin_pkg::timer_route_t       timer_array_route
);
  import sio_pin_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0]        levels;
    logic [NUM_CH-1:0]  drive_en;
    logic [1:0]         invert;
    logic [4:0]         routing;
    logic [1:0]         filter_en;
    logic [NUM_RUN-1:0] run;
    serial_pins_t       pins;
    logic               pin_o;
    logic               pin_oe;
    timer_route_t       troute;
    logic               extint;
    logic [31:0]        rdata;
  } block_state_t;

  block_state_t state_ff;
  block_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin inputs

  logic rx0_lvl;
  logic rx2_lvl;
  logic extint_pin_lvl;
  logic timer7_pin_lvl;
  logic shared_pin_lvl;

  pin_sync_filter u_rx0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (uart0_receive_pin),
    .filter_en (state_ff.filter_en[0]),
    .level     (rx0_lvl)
  );

  pin_sync_filter u_rx2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (uart2_receive_pin),
    .filter_en (state_ff.filter_en[1]),
    .level     (rx2_lvl)
  );

  pin_sync_filter u_extint (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (external_interrupt_zero),
    .filter_en (1'b1),
    .level     (extint_pin_lvl)
  );

  pin_sync_filter u_timer7 (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (timer7_input_pin),
    .filter_en (1'b1),
    .level     (timer7_pin_lvl)
  );

  pin_sync_filter u_shared (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (shared_timer_pin_i),
    .filter_en (1'b1),
    .level     (shared_pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        setup_phase;
  logic        wr_access;
  logic        addr_hit;
  logic [21:0] word_addr;
  logic        addr_high_zero;

  assign word_addr      = paddr[21:0];
  assign addr_high_zero = (paddr[31:22] == 10'h000);
  assign setup_phase    = psel && !penable;
  assign wr_access      = psel && penable && pwrite && addr_hit;

  always_comb
  begin
    addr_hit = 1'b0;
    if (addr_high_zero)
    begin
      case (word_addr)
        ADDR_RX_FILTER_ENABLE,
        ADDR_RUN_STATUS,
        ADDR_START_TRIGGER,
        ADDR_STOP_TRIGGER,
        ADDR_PIN_OUTPUT_LEVELS,
        ADDR_OUTPUT_DRIVE_ENABLE,
        ADDR_TX_LEVEL_INVERSION,
        ADDR_INPUT_ROUTING_SWITCH: addr_hit = 1'b1;
        default:                   addr_hit = 1'b0;
      endcase
    end
  end

  // read data is captured in the setup cycle, so no wait state is needed
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = state_ff.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [2:0] shared_code;
  logic [3:0] start_hits;
  logic [3:0] stop_hits;

  always_comb
  begin
    nxt_state   = state_ff;
    start_hits  = 4'h0;
    stop_hits   = 4'h0;
    shared_code = 3'h0;

    if (wr_access && (word_addr == ADDR_START_TRIGGER))
    begin
      start_hits = pwdata[3:0];
    end
    if (wr_access && (word_addr == ADDR_STOP_TRIGGER))
    begin
      stop_hits = pwdata[3:0];
    end

    nxt_state.run = (state_ff.run & ~stop_hits) | start_hits;

    if (wr_access && (word_addr == ADDR_PIN_OUTPUT_LEVELS))
    begin
      nxt_state.levels[15:11] = pwdata[15:11];
      nxt_state.levels[7:3]   = pwdata[7:3];
    end

    for (int n = 0; n < NUM_CH; n++)
    begin
      // enabled drive: only the transfer changes data
      if (state_ff.drive_en[n])
      begin
        if (xfer_update.data_we[n])
        begin
          nxt_state.levels[POS_DATA_LEVEL + n] = xfer_update.data_lvl[n];
        end
      end
      else if (wr_access && (word_addr == ADDR_PIN_OUTPUT_LEVELS))
      begin
        nxt_state.levels[POS_DATA_LEVEL + n] = pwdata[POS_DATA_LEVEL + n];
      end

      // clock level gated by run status
      if (state_ff.run[n])
      begin
        if (xfer_update.clock_we[n])
        begin
          nxt_state.levels[POS_CLOCK_LEVEL + n] = xfer_update.clock_lvl[n];
        end
      end
      else if (wr_access && (word_addr == ADDR_PIN_OUTPUT_LEVELS))
      begin
        nxt_state.levels[POS_CLOCK_LEVEL + n] = pwdata[POS_CLOCK_LEVEL + n];
      end
    end

    if (wr_access && (word_addr == ADDR_OUTPUT_DRIVE_ENABLE))
    begin
      nxt_state.drive_en = pwdata[NUM_CH-1:0];
    end

    // only channels 0 and 2 invertible
    if (wr_access && (word_addr == ADDR_TX_LEVEL_INVERSION))
    begin
      nxt_state.invert = {pwdata[POS_INV_CH2], pwdata[POS_INV_CH0]};
    end

    if (wr_access && (word_addr == ADDR_INPUT_ROUTING_SWITCH))
    begin
      nxt_state.routing = pwdata[4:0];
    end

    // filter bits at 0 and 2
    if (wr_access && (word_addr == ADDR_RX_FILTER_ENABLE))
    begin
      nxt_state.filter_en = {pwdata[POS_FILTER_CH2], pwdata[POS_FILTER_CH0]};
    end

    // pins follow the new register values on the same edge
    for (int n = 0; n < NUM_CH; n++)
    begin
      nxt_state.pins.clock[n] = nxt_state.levels[POS_CLOCK_LEVEL + n];
      nxt_state.pins.data[n]  = nxt_state.levels[POS_DATA_LEVEL + n];
    end
    if (nxt_state.drive_en[0] && nxt_state.invert[0])
    begin
      nxt_state.pins.data[0] = ~nxt_state.levels[POS_DATA_LEVEL];
    end
    if (nxt_state.drive_en[2] && nxt_state.invert[1])
    begin
      nxt_state.pins.data[2] = ~nxt_state.levels[POS_DATA_LEVEL + 2];
    end

    nxt_state.extint = nxt_state.routing[POS_EXTINT_SEL] ? rx0_lvl : extint_pin_lvl;

    nxt_state.troute.ch7_in = nxt_state.routing[POS_TIMER7_SEL] ? rx0_lvl : timer7_pin_lvl;

    nxt_state.troute.use_shared = 6'h00;
    nxt_state.pin_o             = 1'b1;
    nxt_state.pin_oe            = 1'b0;
    shared_code                 = nxt_state.routing[POS_SHARED_SEL +: 3];
    case (shared_code)
      SHARED_TO_CH1,
      SHARED_TO_CH0,
      SHARED_TO_CH8,
      SHARED_TO_CH9,
      SHARED_TO_CH10,
      SHARED_TO_CH11:
      begin
        nxt_state.troute.use_shared[shared_code] = 1'b1;
        nxt_state.pin_o  = timer_array_out[shared_code];
        nxt_state.pin_oe = 1'b1;
      end
      // prohibited codes leave the pin undriven
      default:
      begin
        nxt_state.pin_oe = 1'b0;
      end
    endcase
    nxt_state.troute.shared_in = shared_pin_lvl;

    // read data captured in setup phase; triggers read as zero
    if (setup_phase)
    begin
      nxt_state.rdata = 32'h0000_0000;
      if (addr_high_zero)
      begin
        case (word_addr)
          ADDR_RX_FILTER_ENABLE:
          begin
            nxt_state.rdata[POS_FILTER_CH0] = state_ff.filter_en[0];
            nxt_state.rdata[POS_FILTER_CH2] = state_ff.filter_en[1];
          end
          ADDR_RUN_STATUS:
          begin
            nxt_state.rdata[NUM_RUN-1:0] = state_ff.run;
          end
          ADDR_PIN_OUTPUT_LEVELS:
          begin
            nxt_state.rdata[15:0] = state_ff.levels;
          end
          ADDR_OUTPUT_DRIVE_ENABLE:
          begin
            nxt_state.rdata[NUM_CH-1:0] = state_ff.drive_en;
          end
          ADDR_TX_LEVEL_INVERSION:
          begin
            nxt_state.rdata[POS_INV_CH0] = state_ff.invert[0];
            nxt_state.rdata[POS_INV_CH2] = state_ff.invert[1];
          end
          ADDR_INPUT_ROUTING_SWITCH:
          begin
            nxt_state.rdata[4:0] = state_ff.routing;
          end
          default:
          begin
            nxt_state.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // every change except the asynchronous reset lands on the next clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff.levels            <= RST_PIN_OUTPUT_LEVELS;
      state_ff.drive_en          <= RST_OUTPUT_DRIVE_ENABLE;
      state_ff.invert            <= RST_TX_LEVEL_INVERSION;
      state_ff.routing           <= RST_INPUT_ROUTING_SWITCH;
      state_ff.filter_en         <= RST_RX_FILTER_ENABLE;
      state_ff.run               <= RST_RUN_STATUS;
      state_ff.pins.data         <= RST_PIN_OUTPUT_LEVELS[POS_DATA_LEVEL +: NUM_CH];
      state_ff.pins.clock        <= RST_PIN_OUTPUT_LEVELS[POS_CLOCK_LEVEL +: NUM_CH];
      state_ff.pin_o             <= 1'b1;
      state_ff.pin_oe            <= 1'b0;
      state_ff.troute.use_shared <= 6'h00;
      state_ff.troute.shared_in  <= 1'b1;
      state_ff.troute.ch7_in     <= 1'b1;
      state_ff.extint            <= 1'b1;
      state_ff.rdata             <= 32'h0000_0000;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_pins         = state_ff.pins;
  assign channel_run_status  = state_ff.run;
  assign uart0_rx_level      = rx0_lvl;
  assign uart2_rx_level      = rx2_lvl;
  assign extint0_level       = state_ff.extint;
  assign shared_timer_pin_o  = state_ff.pin_o;
  assign shared_timer_pin_oe = state_ff.pin_oe;
  assign timer_array_route   = state_ff.troute;

endmodule : sio_pin_route

//--- bench/sio_pin_route_assertions.sv
// concurrent checks on the ports of the serial pin routing block
`timescale 1ns/1ps
module sio_pin_route_assertions (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pready,
  input wire sio_pin_pkg::xfer_update_t  xfer_update,
  input wire sio_pin_pkg::serial_pins_t  serial_pins,
  input wire logic [3:0]                 channel_run_status
);
  import sio_pin_pkg::*;
  logic       wr;
  logic       wr_lv;
  logic [2:0] drv_en_ff;
  logic [2:0] inv_ff;
  assign wr = psel & penable & pwrite & pready;
  assign wr_lv = wr && paddr == {10'h000, ADDR_PIN_OUTPUT_LEVELS};
  // shadow of the gate bits: they never reach a port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_en_ff <= 3'h0;
      inv_ff <= 3'h0;
    end
    else if (wr && paddr == {10'h000, ADDR_OUTPUT_DRIVE_ENABLE})
      drv_en_ff <= pwdata[2:0];
    else if (wr && paddr == {10'h000, ADDR_TX_LEVEL_INVERSION})
      inv_ff <= pwdata[2:0] & 3'h5;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_reset_pins_high: assert property ($rose(presetn) |-> serial_pins == 6'h3F)
    else $error("pins not high after reset");
  a_start_sets_run: assert property (wr && paddr == {10'h000, ADDR_START_TRIGGER}
    |=> (channel_run_status & $past(pwdata[3:0])) == $past(pwdata[3:0]))
    else $error("start did not set run");
  a_stop_clears_run: assert property (wr && paddr == {10'h000, ADDR_STOP_TRIGGER}
    |=> (channel_run_status & $past(pwdata[3:0])) == 4'h0)
    else $error("stop did not clear run");
  a_clock_sw_write: assert property (wr_lv && !channel_run_status[0]
    |=> serial_pins.clock[0] == $past(pwdata[8]))
    else $error("clock level write lost");
  a_clock_run_locked: assert property (wr_lv && channel_run_status[1] && !xfer_update.clock_we[1]
    |=> $stable(serial_pins.clock[1]))
    else $error("clock level written while running");
  a_clock_xfer_moves: assert property (xfer_update.clock_we[1] && channel_run_status[1]
    |=> serial_pins.clock[1] == $past(xfer_update.clock_lvl[1]))
    else $error("transfer clock update lost");
  a_data_sw_write: assert property (wr_lv && !drv_en_ff[2] |=> serial_pins.data[2] == $past(pwdata[2]))
    else $error("data level write lost");
  a_data_sw_ignored: assert property (wr_lv && drv_en_ff[0] && !xfer_update.data_we[0]
    |=> $stable(serial_pins.data[0]))
    else $error("data level written while driven");
  a_data_xfer_invert: assert property (xfer_update.data_we[0] && drv_en_ff[0]
    |=> serial_pins.data[0] == ($past(xfer_update.data_lvl[0]) ^ inv_ff[0]))
    else $error("transfer data level wrong");
  a_data_gated_off: assert property (xfer_update.data_we[1] && !drv_en_ff[1] && !wr_lv
    |=> $stable(serial_pins.data[1]))
    else $error("transfer drove a stopped output");
endmodule : sio_pin_route_assertions
bind sio_pin_route sio_pin_route_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .xfer_update(xfer_update), .serial_pins(serial_pins), .channel_run_status(channel_run_status));

//--- bench/sio_far_side_model.sv
// far-side model: serial engine level updates and timer array outputs
`timescale 1ns/1ps
module sio_far_side_model (
  input  wire logic                 pclk,
  output sio_pin_pkg::xfer_update_t xfer_update,
  output logic [5:0]                timer_array_out
);
  import sio_pin_pkg::*;
  initial
  begin
    xfer_update = '0;
    timer_array_out = 6'h29;
  end
  // one-cycle update; the engine does not know the gates, the block must apply them
  task automatic pulse(input logic is_clk, input int ch, input logic lvl);
    @(posedge pclk);
    xfer_update.clock_we[ch] <= is_clk;
    xfer_update.data_we[ch] <= !is_clk;
    xfer_update.clock_lvl[ch] <= lvl;
    xfer_update.data_lvl[ch] <= lvl;
    @(posedge pclk);
    xfer_update.clock_we <= 3'h0;
    xfer_update.data_we <= 3'h0;
    xfer_update.clock_lvl[ch] <= !lvl;
    xfer_update.data_lvl[ch] <= !lvl;
    #1;
  endtask : pulse
endmodule : sio_far_side_model

//--- bench/sio_pin_route_tb.sv
// self-checking bench for the serial pin routing block
`timescale 1ns/1ps
module sio_pin_route_tb;
  import sio_pin_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [31:0]  paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic         rx0 = 1'b1, rx2 = 1'b1, eint = 1'b1, t7 = 1'b1, sh_i = 1'b1;
  logic         rx0_lvl, rx2_lvl, eint_lvl, sh_o, sh_oe;
  logic [3:0]   run;
  logic [5:0]   tmr_out;
  xfer_update_t xu;
  serial_pins_t pins;
  timer_route_t route;
  int           err_total = 0, checks_done = 0;
  always #12.5 pclk = ~pclk;
  sio_pin_route dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_update(xu), .serial_pins(pins), .channel_run_status(run), .uart0_receive_pin(rx0),
    .uart2_receive_pin(rx2), .uart0_rx_level(rx0_lvl), .uart2_rx_level(rx2_lvl),
    .external_interrupt_zero(eint), .extint0_level(eint_lvl), .timer7_input_pin(t7),
    .shared_timer_pin_i(sh_i), .shared_timer_pin_o(sh_o), .shared_timer_pin_oe(sh_oe),
    .timer_array_out(tmr_out), .timer_array_route(route));
  sio_far_side_model far_u (.pclk(pclk), .xfer_update(xu), .timer_array_out(tmr_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [21:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {10'h000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rdchk(input logic [21:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(ADDR_PIN_OUTPUT_LEVELS, 32'h0000_0F0F);
    rdchk(ADDR_OUTPUT_DRIVE_ENABLE, 32'h0);
    rdchk(ADDR_TX_LEVEL_INVERSION, 32'h0);
    rdchk(ADDR_INPUT_ROUTING_SWITCH, 32'h0);
    rdchk(ADDR_RX_FILTER_ENABLE, 32'h0);
    rdchk(ADDR_RUN_STATUS, 32'h0);
    chk(pins, 6'h3F);
    apb(1'b0, 22'h000010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_reset
  task automatic t_data;
    apb(1'b1, ADDR_PIN_OUTPUT_LEVELS, 32'h0000_0F0A);
    chk(pins.data, 3'h2);
    apb(1'b1, ADDR_OUTPUT_DRIVE_ENABLE, 32'h7);
    apb(1'b1, ADDR_PIN_OUTPUT_LEVELS, 32'h0000_0F0D);
    rdchk(ADDR_PIN_OUTPUT_LEVELS, 32'h0000_0F0A);
    far_u.pulse(1'b0, 0, 1'b1);
    chk(pins.data, 3'h3);
    apb(1'b1, ADDR_OUTPUT_DRIVE_ENABLE, 32'h0);
    far_u.pulse(1'b0, 1, 1'b0);
    chk(pins.data, 3'h3);
  endtask : t_data
  task automatic t_invert;
    apb(1'b1, ADDR_TX_LEVEL_INVERSION, 32'h0000_FFFF);
    rdchk(ADDR_TX_LEVEL_INVERSION, 32'h5);
    chk(pins.data, 3'h3);
    apb(1'b1, ADDR_OUTPUT_DRIVE_ENABLE, 32'h7);
    chk(pins.data, 3'h6);
    far_u.pulse(1'b0, 2, 1'b1);
    chk(pins.data, 3'h2);
    apb(1'b1, ADDR_OUTPUT_DRIVE_ENABLE, 32'h0);
    chk(pins.data, 3'h7);
    apb(1'b1, ADDR_TX_LEVEL_INVERSION, 32'h0);
  endtask : t_invert
  task automatic t_clock;
    apb(1'b1, ADDR_START_TRIGGER, 32'h2);
    chk(run, 4'h2);
    rdchk(ADDR_START_TRIGGER, 32'h0);
    apb(1'b1, ADDR_PIN_OUTPUT_LEVELS, 32'h0000_080F);
    chk(pins.clock, 3'h2);
    far_u.pulse(1'b1, 1, 1'b0);
    chk(pins.clock, 3'h0);
    far_u.pulse(1'b1, 0, 1'b1);
    chk(pins.clock, 3'h0);
    apb(1'b1, ADDR_STOP_TRIGGER, 32'h2);
    chk(run, 4'h0);
    apb(1'b1, ADDR_PIN_OUTPUT_LEVELS, 32'h0000_0F0F);
    chk(pins, 6'h3F);
  endtask : t_clock
  task automatic t_route;
    apb(1'b1, ADDR_INPUT_ROUTING_SWITCH, 32'h3);
    @(posedge pclk);
    rx0 <= 1'b0;
    repeat (8) @(posedge pclk);
    #1 chk({eint_lvl, route.ch7_in}, 2'h0);
    apb(1'b1, ADDR_INPUT_ROUTING_SWITCH, 32'h0);
    repeat (8) @(posedge pclk);
    #1 chk({eint_lvl, route.ch7_in}, 2'h3);
    @(posedge pclk);
    eint <= 1'b0;
    t7 <= 1'b0;
    sh_i <= 1'b0;
    repeat (8) @(posedge pclk);
    #1 chk({eint_lvl, route.ch7_in, route.shared_in}, 3'h0);
    @(posedge pclk);
    rx0 <= 1'b1;
    eint <= 1'b1;
    t7 <= 1'b1;
    sh_i <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, ADDR_INPUT_ROUTING_SWITCH, 32'(c) << 2);
      repeat (3) @(posedge pclk);
      #1 chk(route.use_shared, c < 6 ? 6'h01 << c : 6'h00);
      if (c < 6)
        chk({sh_oe, sh_o}, {1'b1, tmr_out[c]});
      else
        chk(sh_oe, 1'b0);
    end
  endtask : t_route
  // one-cycle low on both receive pins; with filt set the filter must swallow it, with filt clear it must show
  task automatic glitch(input logic filt);
    logic seen = 1'b0;
    @(posedge pclk);
    rx0 <= 1'b0;
    rx2 <= 1'b0;
    @(posedge pclk);
    rx0 <= 1'b1;
    rx2 <= 1'b1;
    repeat (8)
    begin
      @(posedge pclk);
      #1 seen = seen | !rx0_lvl | !rx2_lvl;
    end
    chk(seen, !filt);
  endtask : glitch
  task automatic t_filter;
    apb(1'b1, ADDR_RX_FILTER_ENABLE, 32'h5);
    rdchk(ADDR_RX_FILTER_ENABLE, 32'h5);
    glitch(1'b1);
    apb(1'b1, ADDR_RX_FILTER_ENABLE, 32'h0);
    glitch(1'b0);
  endtask : t_filter
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_data;
    t_invert;
    t_clock;
    t_route;
    t_filter;
    tally_and_finish;
  end
  // whole run is a few hundred cycles; 2000 means a hang
  initial
  begin
    #50000;
    err_total++;
    tally_and_finish;
  end
endmodule : sio_pin_route_tb
